// ### core/host_port_pkg.sv
// constants for the multiplexed host bus port
package host_port_pkg;
  // ***************************************************
  // widths
  // ***************************************************
  localparam int unsigned HALF_W   = 16;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned AXI_AW   = 12;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned BUF_W    = 7;
  localparam int unsigned DS_WORDS = 4;

  // ***************************************************
  // register indices (byte address = 4 * index)
  // ***************************************************
  localparam logic [IDX_W-1:0] IDX_ASSIST   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_OUT_CTRL = 3'h1;
  localparam logic [IDX_W-1:0] IDX_IN_MASK  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_IN_CMD   = 3'h3;
  localparam logic [IDX_W-1:0] IDX_DS_BASE  = 3'h4;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int unsigned ASSIST_EN_BIT  = 0;
  localparam int unsigned ASSIST_POL_BIT = 1;
  localparam int unsigned ASSIST_OE_BIT  = 2;
  localparam int unsigned OUT_BUSY_BIT   = 15;
  localparam int unsigned OUT_FETCH_BIT  = 9;
  localparam int unsigned OUT_SWAP_BIT   = 8;
  localparam int unsigned OUT_HOST_LSB   = 16;
  localparam int unsigned IN_LOAD_BIT    = 1;
  localparam int unsigned IN_BUSY_BIT    = 15;

  // ***************************************************
  // reset values and answers
  // ***************************************************
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
  localparam logic [BUF_W-1:0]  BUF_ZERO  = 7'h00;
  localparam logic [1:0]        RESP_OKAY = 2'h0;
  localparam logic [1:0]        RESP_SLV  = 2'h2;
  localparam logic [1:0]        STRAP_CNT = 2'h3;

  // ***************************************************
  // host access sequencer
  // ***************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_EDGE, ST_REL, ST_END} hp_state_t;
endpackage

// ### core/mux_host_bus_dma_port.sv
// multiplexed 16-bit host bus port with transfer request pin and register file
// Operation
// - rising-strobe mode latches address on rising edge of address_strobe
// - falling-strobe mode latches address on falling edge of addr_latch_strobe
// - rising mode read: wait low at next bus clock rise, release on rise
// - falling mode read: wait low at next bus clock fall, release on rise
// - data drivers off as soon as chip select or read strobe goes high
// - rising mode write: capture on rise, wait low, release after internal write
// - falling mode write: capture and wait low on fall, release on rise
// - wait low at most five bus clocks with 80 MHz core clock
// - wait low at most seven bus clocks with 40 MHz core clock
// - falling mode limit adds one bus clock low phase
// - first half read copies register; second read uses the copy
// - rising mode reads upper half first, lower second
// - falling mode reads lower half first, upper second
// - rising mode writes upper half first, lower second
// - falling mode writes lower half first, upper second
// - word stored only on second half write
// - request pin driven only while output enabled
// - polarity bit clear gives active-high request signalling
// - enable bit set drives pin active; clear makes it inactive
// - fetch and swap writes accepted only while out_busy_r is clear
`timescale 1ns/100ps
`default_nettype none
module mux_host_bus_dma_port
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // mode strap, high selects falling-strobe mode
  input  wire logic                  falling_strobe_mode,
  // host bus pins
  input  wire logic                  host_bus_clock,
  input  wire logic                  chip_select_n,
  input  wire logic                  read_strobe_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  address_strobe_n,
  input  wire logic                  addr_latch_strobe,
  input  wire logic [15:0]           muxed_addr_data_in,
  output logic      [15:0]           muxed_addr_data_out,
  output logic                       muxed_addr_data_oe_n,
  output logic                       wait_release_out,
  // transfer request pin
  output logic                       transfer_request_pin,
  output logic                       transfer_request_oe_n,
  // message handler side
  output logic                       out_fetch_req,
  output logic                       out_swap_req,
  input  wire logic                  out_fetch_done,
  output logic                       in_xfer_req,
  output logic      [6:0]            in_target_index,
  input  wire logic                  in_xfer_done,
  // axi4-lite slave
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [6:0]  pin_meta_r;
  logic [6:0]  pin_sync_r;
  logic        bclk_d_r;
  logic        as_d_r;
  logic        ale_d_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_r <= 7'h7E;
      pin_sync_r <= 7'h7E;
    end
    else
    begin
      pin_meta_r <= {falling_strobe_mode, host_bus_clock, chip_select_n, read_strobe_n,
                     write_strobe_n, address_strobe_n, addr_latch_strobe};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic [15:0] bus_sync_r;
  logic [15:0] bus_meta_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_meta_r <= host_port_pkg::HALF_ZERO;
      bus_sync_r <= host_port_pkg::HALF_ZERO;
    end
    else
    begin
      bus_meta_r <= muxed_addr_data_in;
      bus_sync_r <= bus_meta_r;
    end
  end

  logic strap_s;
  logic bclk_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic as_s;
  logic ale_s;
  assign strap_s = pin_sync_r[6];
  assign bclk_s  = pin_sync_r[5];
  assign cs_s    = pin_sync_r[4];
  assign rd_s    = pin_sync_r[3];
  assign wr_s    = pin_sync_r[2];
  assign as_s    = pin_sync_r[1];
  assign ale_s   = pin_sync_r[0];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bclk_d_r <= 1'b1;
      as_d_r   <= 1'b1;
      ale_d_r  <= 1'b0;
    end
    else
    begin
      bclk_d_r <= bclk_s;
      as_d_r   <= as_s;
      ale_d_r  <= ale_s;
    end
  end

  logic bclk_rise;
  logic bclk_fall;
  assign bclk_rise = bclk_s & ~bclk_d_r;
  assign bclk_fall = ~bclk_s & bclk_d_r;

  // ***************************************************
  // mode strap capture after reset release
  // ***************************************************
  logic [1:0] strap_cnt_r;
  logic       fall_mode_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_cnt_r <= 2'h0;
      fall_mode_r <= 1'b0;
    end
    else if (strap_cnt_r != host_port_pkg::STRAP_CNT)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      fall_mode_r <= strap_s;
    end
  end

  // ***************************************************
  // address latch
  // ***************************************************
  logic [15:0] addr_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      addr_r <= host_port_pkg::HALF_ZERO;
    else if (!fall_mode_r && as_s && !as_d_r)
      addr_r <= bus_sync_r;
    else if (fall_mode_r && !ale_s && ale_d_r)
      addr_r <= bus_sync_r;
  end

  logic [2:0] host_idx;
  assign host_idx = addr_r[host_port_pkg::IDX_LSB +: host_port_pkg::IDX_W];

  // ***************************************************
  // register file
  // ***************************************************
  logic [31:0] assist_r;
  logic [6:0]  out_shadow_idx_r;
  logic [6:0]  out_host_idx_r;
  logic        out_busy_r;
  logic        load_ds_r;
  logic [6:0]  in_idx_r;
  logic        in_busy_r;
  logic [31:0] ds_r [host_port_pkg::DS_WORDS];

  logic        reg_we;
  logic [2:0]  reg_widx;
  logic [31:0] reg_wdata;

  function automatic logic [31:0] reg_read(input logic [2:0] idx);
    logic [31:0] v;
    v = host_port_pkg::WORD_ZERO;
    case (idx)
      host_port_pkg::IDX_ASSIST:
        v = assist_r;
      host_port_pkg::IDX_OUT_CTRL:
      begin
        v[host_port_pkg::OUT_HOST_LSB +: host_port_pkg::BUF_W] = out_host_idx_r;
        v[host_port_pkg::OUT_BUSY_BIT] = out_busy_r;
        v[host_port_pkg::BUF_W-1:0] = out_shadow_idx_r;
      end
      host_port_pkg::IDX_IN_MASK:
        v[host_port_pkg::IN_LOAD_BIT] = load_ds_r;
      host_port_pkg::IDX_IN_CMD:
      begin
        v[host_port_pkg::IN_BUSY_BIT] = in_busy_r;
        v[host_port_pkg::BUF_W-1:0] = in_idx_r;
      end
      default:
        v = ds_r[idx[1:0]];
    endcase
    return v;
  endfunction

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      assist_r <= host_port_pkg::WORD_ZERO;
    else if (reg_we && reg_widx == host_port_pkg::IDX_ASSIST)
      assist_r <= {29'h0000_0000, reg_wdata[2:0]};
  end

  // transfer request pin
  always_comb
  begin
    transfer_request_oe_n = ~assist_r[host_port_pkg::ASSIST_OE_BIT];
    transfer_request_pin  = assist_r[host_port_pkg::ASSIST_EN_BIT]
                          ^ assist_r[host_port_pkg::ASSIST_POL_BIT];
  end

  logic out_ctrl_we;
  assign out_ctrl_we = reg_we && reg_widx == host_port_pkg::IDX_OUT_CTRL && !out_busy_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_shadow_idx_r <= host_port_pkg::BUF_ZERO;
      out_host_idx_r   <= host_port_pkg::BUF_ZERO;
      out_busy_r       <= 1'b0;
      out_fetch_req    <= 1'b0;
      out_swap_req     <= 1'b0;
    end
    else
    begin
      out_fetch_req <= out_ctrl_we && reg_wdata[host_port_pkg::OUT_FETCH_BIT];
      out_swap_req  <= out_ctrl_we && reg_wdata[host_port_pkg::OUT_SWAP_BIT];
      if (out_ctrl_we)
        out_shadow_idx_r <= reg_wdata[host_port_pkg::BUF_W-1:0];
      if (out_ctrl_we && reg_wdata[host_port_pkg::OUT_SWAP_BIT])
        out_host_idx_r <= out_shadow_idx_r;
      // set wins over the done pulse
      if (out_ctrl_we && reg_wdata[host_port_pkg::OUT_FETCH_BIT])
        out_busy_r <= 1'b1;
      else if (out_fetch_done)
        out_busy_r <= 1'b0;
    end
  end

  logic in_cmd_we;
  assign in_cmd_we = reg_we && reg_widx == host_port_pkg::IDX_IN_CMD && !in_busy_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      load_ds_r   <= 1'b0;
      in_idx_r    <= host_port_pkg::BUF_ZERO;
      in_busy_r   <= 1'b0;
      in_xfer_req <= 1'b0;
    end
    else
    begin
      in_xfer_req <= in_cmd_we;
      if (reg_we && reg_widx == host_port_pkg::IDX_IN_MASK)
        load_ds_r <= reg_wdata[host_port_pkg::IN_LOAD_BIT];
      if (in_cmd_we)
        in_idx_r <= reg_wdata[host_port_pkg::BUF_W-1:0];
      if (in_cmd_we)
        in_busy_r <= 1'b1;
      else if (in_xfer_done)
        in_busy_r <= 1'b0;
    end
  end

  assign in_target_index = in_idx_r;

  genvar g;
  generate
    for (g = 0; g < host_port_pkg::DS_WORDS; g++)
    begin : g_ds
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          ds_r[g] <= host_port_pkg::WORD_ZERO;
        else if (reg_we && reg_widx == host_port_pkg::IDX_DS_BASE + 3'(g))
          ds_r[g] <= reg_wdata;
      end
    end
  endgenerate

  // ***************************************************
  // host access sequencer
  // ***************************************************
  host_port_pkg::hp_state_t st_r;
  logic        is_wr_r;
  logic        rd_phase_r;
  logic        wr_phase_r;
  logic [31:0] rd_temp_r;
  logic [31:0] wr_temp_r;
  logic [15:0] rd_half_r;
  logic        host_we;

  logic rd_act;
  logic wr_act;
  logic own_edge;
  assign rd_act   = !cs_s && !rd_s;
  assign wr_act   = !cs_s && !wr_s;
  assign own_edge = fall_mode_r ? bclk_fall : bclk_rise;

  logic [31:0] host_word;
  assign host_word = reg_read(host_idx);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r             <= host_port_pkg::ST_IDLE;
      is_wr_r          <= 1'b0;
      rd_phase_r       <= 1'b0;
      wr_phase_r       <= 1'b0;
      rd_temp_r        <= host_port_pkg::WORD_ZERO;
      wr_temp_r        <= host_port_pkg::WORD_ZERO;
      rd_half_r        <= host_port_pkg::HALF_ZERO;
      host_we          <= 1'b0;
      wait_release_out <= 1'b1;
    end
    else
    begin
      host_we <= 1'b0;
      case (st_r)
        host_port_pkg::ST_IDLE:
        begin
          if (rd_act || wr_act)
          begin
            is_wr_r <= wr_act;
            st_r    <= host_port_pkg::ST_EDGE;
          end
        end
        host_port_pkg::ST_EDGE:
        begin
          if (!(rd_act || wr_act))
            st_r <= host_port_pkg::ST_IDLE;
          else if (own_edge)
          begin
            wait_release_out <= 1'b0;
            st_r             <= host_port_pkg::ST_REL;
            if (is_wr_r)
            begin
              wr_phase_r <= ~wr_phase_r;
              if (wr_phase_r == fall_mode_r)
                wr_temp_r[31:16] <= bus_sync_r;
              else
                wr_temp_r[15:0] <= bus_sync_r;
              host_we <= wr_phase_r;
            end
            else
            begin
              rd_phase_r <= ~rd_phase_r;
              if (!rd_phase_r)
              begin
                rd_temp_r <= host_word;
                rd_half_r <= fall_mode_r ? host_word[15:0] : host_word[31:16];
              end
              else
                rd_half_r <= fall_mode_r ? rd_temp_r[31:16] : rd_temp_r[15:0];
            end
          end
        end
        host_port_pkg::ST_REL:
        begin
          // next rise bounds the low time
          if (bclk_rise)
          begin
            wait_release_out <= 1'b1;
            st_r             <= host_port_pkg::ST_END;
          end
        end
        host_port_pkg::ST_END:
        begin
          if (!(rd_act || wr_act))
            st_r <= host_port_pkg::ST_IDLE;
        end
        default:
          st_r <= host_port_pkg::ST_IDLE;
      endcase
    end
  end

  // read data appears when wait is released
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      muxed_addr_data_out <= host_port_pkg::HALF_ZERO;
    else if (st_r == host_port_pkg::ST_REL && bclk_rise && !is_wr_r)
      muxed_addr_data_out <= rd_half_r;
  end

  assign muxed_addr_data_oe_n = ~rd_act;

  // ***************************************************
  // axi4-lite slave
  // ***************************************************
  logic axi_wr_go;
  logic awaddr_ok;
  logic araddr_ok;
  assign awaddr_ok = s_axi_awaddr[11:5] == 7'h00;
  assign araddr_ok = s_axi_araddr[11:5] == 7'h00;
  // host writes win the shared write port; axi waits a cycle
  assign axi_wr_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !host_we;
  assign s_axi_awready = axi_wr_go;
  assign s_axi_wready  = axi_wr_go;
  assign s_axi_arready = !s_axi_rvalid;

  logic [31:0] axi_wmask;
  always_comb
  begin
    axi_wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    reg_we    = host_we || (axi_wr_go && awaddr_ok);
    reg_widx  = host_we ? host_idx : s_axi_awaddr[host_port_pkg::IDX_LSB +: host_port_pkg::IDX_W];
    reg_wdata = host_we ? wr_temp_r
              : ((s_axi_wdata & axi_wmask) | (reg_read(reg_widx) & ~axi_wmask));
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= host_port_pkg::RESP_OKAY;
    end
    else if (axi_wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= awaddr_ok ? host_port_pkg::RESP_OKAY : host_port_pkg::RESP_SLV;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= host_port_pkg::WORD_ZERO;
      s_axi_rresp  <= host_port_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= araddr_ok ? reg_read(s_axi_araddr[host_port_pkg::IDX_LSB +: host_port_pkg::IDX_W])
                                : host_port_pkg::WORD_ZERO;
      s_axi_rresp  <= araddr_ok ? host_port_pkg::RESP_OKAY : host_port_pkg::RESP_SLV;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ### verif/host_port_monitor.sv
// assertion checker for the multiplexed host bus port
`timescale 1ns/100ps
`default_nettype none
module host_port_monitor
#(
  parameter int BCLK_CYC = 16
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // host bus
  input wire logic falling_strobe_mode,
  input wire logic host_bus_clock,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic muxed_addr_data_oe_n,
  input wire logic wait_release_out,
  // message handler side
  input wire logic out_fetch_req,
  input wire logic out_fetch_done,
  input wire logic in_xfer_req,
  input wire logic in_xfer_done
);
  logic [7:0] low_r;
  logic       fbusy_r;
  logic       ibusy_r;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      low_r <= 8'h00;
    else
      low_r <= wait_release_out ? 8'h00 : low_r + 8'h01;

  // mirrors of the busy flags, set wins over done
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      fbusy_r <= 1'b0;
    else if (out_fetch_req || out_fetch_done)
      fbusy_r <= out_fetch_req;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      ibusy_r <= 1'b0;
    else if (in_xfer_req || in_xfer_done)
      ibusy_r <= in_xfer_req;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_oe_release: assert property ((chip_select_n || read_strobe_n) [*4] |-> muxed_addr_data_oe_n)
    else $error("bus drivers on after strobe release");
  chk_wait_bound: assert property (low_r < 5 * BCLK_CYC + (falling_strobe_mode ? BCLK_CYC / 2 : 0))
    else $error("wait held low too long");
  chk_wait_cause: assert property ($fell(wait_release_out) |-> $past(!chip_select_n && !(read_strobe_n && write_strobe_n), 2))
    else $error("wait fell without an access");
  chk_fall_rise: assert property ($fell(wait_release_out) && !falling_strobe_mode |-> host_bus_clock)
    else $error("wait fell off a rising bus clock");
  chk_fall_fall: assert property ($fell(wait_release_out) && falling_strobe_mode |-> !host_bus_clock)
    else $error("wait fell off a falling bus clock");
  chk_rel_rise: assert property ($rose(wait_release_out) |-> host_bus_clock)
    else $error("wait released off a rising bus clock");
  chk_fetch_once: assert property (out_fetch_req |-> !fbusy_r)
    else $error("fetch accepted while busy");
  chk_xfer_once: assert property (in_xfer_req |-> !ibusy_r)
    else $error("transfer accepted while busy");
endmodule
bind mux_host_bus_dma_port host_port_monitor i_host_port_monitor (
  .mclk, .nrst, .falling_strobe_mode, .host_bus_clock, .chip_select_n, .read_strobe_n, .write_strobe_n,
  .muxed_addr_data_oe_n, .wait_release_out, .out_fetch_req, .out_fetch_done, .in_xfer_req, .in_xfer_done);
`default_nettype wire

// ### verif/host_cpu_model.sv
// host cpu model driving the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model
(
  // clock
  input  wire logic        mclk,
  // bus pins
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             address_strobe_n,
  output logic             addr_latch_strobe,
  output logic [15:0]      muxed_addr_data_in,
  input  wire logic [15:0] muxed_addr_data_out,
  input  wire logic        muxed_addr_data_oe_n,
  input  wire logic        wait_release_out
);
  logic [15:0] bus_r;

  // released bus shows the inverse of its last value
  assign muxed_addr_data_in = muxed_addr_data_oe_n ? bus_r : muxed_addr_data_out;

  initial
  begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    address_strobe_n = 1'b1;
    addr_latch_strobe = 1'b0;
    bus_r = 16'h0000;
  end

  // one half access
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    bus_r <= a;
    address_strobe_n <= 1'b0;
    addr_latch_strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    address_strobe_n <= 1'b1;
    addr_latch_strobe <= 1'b0;
    repeat (4) @(posedge mclk);
    bus_r <= wr ? d : ~a;
    chip_select_n <= 1'b0;
    read_strobe_n <= wr;
    write_strobe_n <= !wr;
    do @(posedge mclk); while (wait_release_out === 1'b1);
    do @(posedge mclk); while (wait_release_out !== 1'b1);
    q = muxed_addr_data_out;
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    bus_r <= ~bus_r;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### verif/test_mux_host_bus_dma_port.sv
// self-checking bench for the multiplexed host bus port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module test_mux_host_bus_dma_port;
  logic        mclk, nrst, strap, bclk, cs_n, rd_n, wr_n, as_n, ale, d_oe_n, wrdy, rq_pin, rq_oe_n;
  logic        fetch_req, swap_req, fetch_done, xfer_req, xfer_done;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] d_in, d_out;
  logic [6:0]  tgt, t;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, g;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] mem [8];
  int          n_mismatch, checked, n_fetch, n_swap, n_xfer, f, s, x;

  mux_host_bus_dma_port i_mux_host_bus_dma_port (.mclk(mclk), .nrst(nrst), .falling_strobe_mode(strap),
    .host_bus_clock(bclk), .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .address_strobe_n(as_n), .addr_latch_strobe(ale), .muxed_addr_data_in(d_in), .muxed_addr_data_out(d_out),
    .muxed_addr_data_oe_n(d_oe_n), .wait_release_out(wrdy), .transfer_request_pin(rq_pin),
    .transfer_request_oe_n(rq_oe_n), .out_fetch_req(fetch_req), .out_swap_req(swap_req),
    .out_fetch_done(fetch_done), .in_xfer_req(xfer_req), .in_target_index(tgt), .in_xfer_done(xfer_done),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  host_cpu_model i_host_cpu_model (.mclk(mclk), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .address_strobe_n(as_n), .addr_latch_strobe(ale), .muxed_addr_data_in(d_in),
    .muxed_addr_data_out(d_out), .muxed_addr_data_oe_n(d_oe_n), .wait_release_out(wrdy));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    bclk = 1'b0;
    #13;
    forever #40 bclk = ~bclk;
  end

  always @(posedge mclk)
  begin
    if (fetch_req === 1'b1) n_fetch++;
    if (swap_req === 1'b1) n_swap++;
    if (xfer_req === 1'b1) n_xfer++;
  end

  function automatic logic [11:0] ad(input logic [2:0] i);
    return {7'h00, i, 2'h0};
  endfunction

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] q);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge mclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge mclk); while (bvalid !== 1'b1);
    q = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] q);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    q = rresp;
    rready <= 1'b0;
  endtask

  // half write pair, checked between halves
  task automatic hw(input logic [2:0] i, input logic [31:0] w);
    logic [15:0] q;
    i_host_cpu_model.acc(1'b1, 16'(ad(i)), strap ? w[15:0] : w[31:16], q);
    axr(ad(i), g, r);
    `CHK(g, mem[i])
    i_host_cpu_model.acc(1'b1, 16'(ad(i)), strap ? w[31:16] : w[15:0], q);
    mem[i] = w;
    axr(ad(i), g, r);
    `CHK(g, w)
  endtask

  // half read pair, register changed between
  task automatic hr(input logic [2:0] i);
    logic [15:0] q1, q2;
    logic [31:0] w;
    w = $urandom;
    i_host_cpu_model.acc(1'b0, 16'(ad(i)), 16'h0000, q1);
    axw(ad(i), w, r);
    i_host_cpu_model.acc(1'b0, 16'(ad(i)), 16'h0000, q2);
    `CHK({q1, q2}, strap ? {mem[i][15:0], mem[i][31:16]} : mem[i])
    mem[i] = w;
  endtask

  task automatic rst(input logic m);
    nrst <= 1'b0;
    strap <= m;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    repeat (4) @(posedge mclk);
    `CHK(wrdy, 1'b1)
    `CHK(rq_pin, 1'b0)
  endtask

  task automatic pulse(input logic fetch);
    if (fetch) fetch_done <= 1'b1;
    else xfer_done <= 1'b1;
    @(posedge mclk);
    fetch_done <= 1'b0;
    xfer_done <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {nrst, strap, fetch_done, xfer_done, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    void'($urandom(17));
    for (int m = 0; m < 2; m++)
    begin
      rst(m[0]);
      for (int i = 4; i < 8; i++)
      begin
        hw(3'(i), (i == 4) ? 32'hFFFF_0000 : $urandom);
        hr(3'(i));
      end
      $display("test host halves in mode %0d done", m);
    end
    for (int v = 0; v < 8; v++)
    begin
      axw(ad(host_port_pkg::IDX_ASSIST), 32'(v), r);
      `CHK(r, host_port_pkg::RESP_OKAY)
      `CHK(rq_pin, v[0] ^ v[1])
      `CHK(rq_oe_n, ~v[2])
    end
    $display("test request pin done");
    f = n_fetch;
    s = n_swap;
    axw(ad(host_port_pkg::IDX_OUT_CTRL), 32'h0000_0200, r);
    axw(ad(host_port_pkg::IDX_OUT_CTRL), 32'h0000_0200, r);
    axw(ad(host_port_pkg::IDX_OUT_CTRL), 32'h0000_0100, r);
    axr(ad(host_port_pkg::IDX_OUT_CTRL), g, r);
    `CHK(g[host_port_pkg::OUT_BUSY_BIT], 1'b1)
    `CHK(n_fetch, f + 1)
    `CHK(n_swap, s)
    pulse(1'b1);
    axr(ad(host_port_pkg::IDX_OUT_CTRL), g, r);
    `CHK(g[host_port_pkg::OUT_BUSY_BIT], 1'b0)
    axw(ad(host_port_pkg::IDX_OUT_CTRL), 32'h0000_0100, r);
    @(posedge mclk);
    `CHK(n_swap, s + 1)
    $display("test output buffer done");
    x = n_xfer;
    t = 7'($urandom);
    axw(ad(host_port_pkg::IDX_IN_MASK), 32'h0000_0002, r);
    axr(ad(host_port_pkg::IDX_IN_CMD), g, r);
    `CHK(g[host_port_pkg::IN_BUSY_BIT], 1'b0)
    axw(ad(host_port_pkg::IDX_IN_CMD), 32'(t), r);
    axw(ad(host_port_pkg::IDX_IN_CMD), 32'(~t), r);
    @(posedge mclk);
    `CHK(n_xfer, x + 1)
    `CHK(tgt, t)
    pulse(1'b0);
    axr(ad(host_port_pkg::IDX_IN_CMD), g, r);
    `CHK(g[host_port_pkg::IN_BUSY_BIT], 1'b0)
    axw(12'h020, $urandom, r);
    `CHK(r, host_port_pkg::RESP_SLV)
    axr(12'h3FC, g, r);
    `CHK(r, host_port_pkg::RESP_SLV)
    `CHK(g, host_port_pkg::WORD_ZERO)
    $display("test input buffer and unmapped done");
    final_report();
  end
endmodule
`default_nettype wire
